// >>> design/alufg_pkg.sv
// package with the ALU host controller encodings and timing constants
package alufg_pkg;
  // operand and select widths
  localparam int ALUFG_W = 4;
  // select codes driven toward the ALU
  localparam logic [3:0] ALUFG_SEL_SUB = 4'h6;
  localparam logic [3:0] ALUFG_SEL_ADD = 4'h9;
  localparam logic [3:0] ALUFG_SEL_DBL = 4'hC;
  localparam logic [3:0] ALUFG_SEL_XFR = 4'hF;
  localparam logic [3:0] ALUFG_SEL_DEC = 4'hF;
  localparam logic [3:0] ALUFG_SEL_ZERO = 4'h3;
  // mode control levels
  localparam logic ALUFG_MODE_ARITH = 1'b0;
  localparam logic ALUFG_MODE_LOGIC = 1'b1;
  // inverted carry pin levels (active-high data)
  localparam logic ALUFG_CN_NOCARRY = 1'b1;
  localparam logic ALUFG_CN_CARRY = 1'b0;
  // settle time for the combinational ALU, in ns
  localparam int ALUFG_SETTLE_NS = 100;
  localparam int ALUFG_CLK_NS = 50;
  localparam int ALUFG_SETTLE_CYC = (ALUFG_SETTLE_NS + ALUFG_CLK_NS - 1) / ALUFG_CLK_NS;
  localparam logic [3:0] ALUFG_SETTLE_CNT = 4'(ALUFG_SETTLE_CYC);
  // host operations
  typedef enum logic [2:0] {
    ALUFG_OP_ADD,
    ALUFG_OP_SUB,
    ALUFG_OP_EQ,
    ALUFG_OP_MAG,
    ALUFG_OP_DEC,
    ALUFG_OP_XFR,
    ALUFG_OP_DBL,
    ALUFG_OP_LOGIC
  } alufg_op_t;
  // pins toward the ALU
  typedef struct packed {
    logic [3:0] func_select;
    logic mode;
    logic carry_in_n;
    logic [3:0] operand_first;
    logic [3:0] operand_second;
  } alufg_drive_t;
  // pins coming back from the ALU
  typedef struct packed {
    logic [3:0] result_word;
    logic carry_out_n;
    logic prop_n;
    logic gen_n;
    logic equal;
  } alufg_sense_t;
  // captured answer
  typedef struct packed {
    logic [3:0] result_word;
    logic carry;
    logic prop_n;
    logic gen_n;
    logic equal;
  } alufg_answer_t;
endpackage

// >>> design/alufg_host.sv
// host controller that drives a 4-bit ALU/function generator through its pins
`timescale 1ns/1ps
`default_nettype none
module alufg_host
  import alufg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire alufg_op_t req_op,
  input wire logic req_carry,
  input wire logic [3:0] req_logic_sel,
  input wire logic [3:0] req_first,
  input wire logic [3:0] req_second,
  output alufg_drive_t alu_drive,
  input wire alufg_sense_t alu_sense,
  output logic ans_valid,
  output alufg_answer_t ans_data
);

  // one request at a time: take, settle, report, then ready again
  // controller states
  typedef enum logic [1:0] {ALUFG_IDLE, ALUFG_WAIT, ALUFG_DONE} alufg_state_t;

  alufg_state_t state_r, state_nxt; // sequencer state
  // cycles from the take edge to the edge that sees the answer pulse
  localparam int ALUFG_ANS_DLY = ALUFG_SETTLE_CYC + 1;
  alufg_drive_t drive_r; // registered pin drive
  alufg_drive_t drive_nxt; // decoded pin drive for a request
  logic [3:0] wait_r; // settle counter
  alufg_answer_t ans_r; // captured answer

  // select code for each host operation
  // codes follow the active-high data reading of the slice
  // logic requests pass the caller's code straight through
  function automatic logic [3:0] alufg_sel(input alufg_op_t op, input logic [3:0] lsel);
    logic [3:0] s;
    s = ALUFG_SEL_ADD;
    unique case (op)
      ALUFG_OP_ADD: s = ALUFG_SEL_ADD;
      ALUFG_OP_SUB, ALUFG_OP_EQ, ALUFG_OP_MAG: s = ALUFG_SEL_SUB;
      ALUFG_OP_DEC: s = ALUFG_SEL_DEC;
      ALUFG_OP_XFR: s = ALUFG_SEL_XFR;
      ALUFG_OP_DBL: s = ALUFG_SEL_DBL;
      ALUFG_OP_LOGIC: s = lsel;
    endcase
    return s;
  endfunction

  // decoded controls for the request now on the inputs
  // logic class turns the internal carries off
  wire logic is_logic = (req_op == ALUFG_OP_LOGIC);
  // magnitude compare and transfer need the carry forced in
  // magnitude: A minus B with carry, carry out set when A is not below B
  // transfer: select all ones gives A minus 1, the carry brings it back to A
  wire logic force_carry = (req_op == ALUFG_OP_MAG) || (req_op == ALUFG_OP_XFR);
  // decrement and equality leave the carry pin at its no-carry level
  // equality: A minus B minus 1 is all ones exactly when the words match
  wire logic no_carry = (req_op == ALUFG_OP_DEC) || (req_op == ALUFG_OP_EQ);
  // other arithmetic takes the caller's carry wish
  wire logic want_carry = force_carry || (!no_carry && req_carry);
  // settle counter has run out
  wire logic settled = (wait_r == 4'h0);

  // build the drive word; carry pin inverted for active-high data
  always_comb begin
    drive_nxt.func_select = alufg_sel(req_op, req_logic_sel);
    drive_nxt.mode = is_logic ? ALUFG_MODE_LOGIC : ALUFG_MODE_ARITH;
    drive_nxt.carry_in_n = want_carry ? ALUFG_CN_CARRY : ALUFG_CN_NOCARRY;
    drive_nxt.operand_first = req_first;
    drive_nxt.operand_second = req_second;
  end

  // ready only while idle, so a request is never taken mid-operation
  assign req_ready = (state_r == ALUFG_IDLE);
  // pins come straight from the drive register
  assign alu_drive = drive_r;
  // answer pulse marks the single cycle spent in DONE
  assign ans_valid = (state_r == ALUFG_DONE);
  // captured answer stands until the next capture
  assign ans_data = ans_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      // idle: take a request as soon as one is offered
      ALUFG_IDLE: if (req_valid) state_nxt = ALUFG_WAIT;
      // wait: pins are driven, give the slice time to settle
      ALUFG_WAIT: if (settled) state_nxt = ALUFG_DONE;
      // done: answer pulse lasts one cycle
      ALUFG_DONE: state_nxt = ALUFG_IDLE;
      // the fourth code is never entered; fall back to idle
      default: state_nxt = ALUFG_IDLE;
    endcase
  end

  // sequencer register
  // reset returns the controller to idle at once, without a clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state_r <= ALUFG_IDLE;
    else state_r <= state_nxt;
  end

  // drive pins on accept; reset drive is an add of two zero words, no carry
  // operands and controls stay frozen until the next take, which keeps
  // the slice steady while it settles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_r <= '{ALUFG_SEL_ADD, ALUFG_MODE_ARITH, ALUFG_CN_NOCARRY, 4'h0, 4'h0};
    end else if (req_ready && req_valid) begin
      drive_r <= drive_nxt;
    end
  end

  // settle counter, combinational ALU needs time only
  // the count starts one short: the edge that leaves WAIT is itself
  // the last settle cycle, so the answer is sampled after the full time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wait_r <= 4'h0;
    else if (req_ready && req_valid) wait_r <= ALUFG_SETTLE_CNT - 4'h1;
    else if (!settled) wait_r <= wait_r - 4'h1;
  end

  // capture the outputs once settled; carry restored to active-high
  // sampled once, at the edge that leaves WAIT, so an answer never mixes
  // the pins of two requests
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ans_r <= '0;
    end else if (state_r == ALUFG_WAIT && settled) begin
      ans_r.result_word <= alu_sense.result_word;
      ans_r.carry <= ~alu_sense.carry_out_n;
      ans_r.prop_n <= alu_sense.prop_n;
      ans_r.gen_n <= alu_sense.gen_n;
      ans_r.equal <= alu_sense.equal;
    end
  end

  // checks on what the controller drives and what it captures
  chk_arith_mode_low: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op != ALUFG_OP_LOGIC) |=> alu_drive.mode == ALUFG_MODE_ARITH)
    else $error("mode not low for arithmetic");
  chk_logic_mode_high: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_LOGIC) |=>
    (alu_drive.mode == ALUFG_MODE_LOGIC && alu_drive.func_select == $past(req_logic_sel)))
    else $error("logic request not driven");
  chk_eq_sub_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_EQ) |=>
    (alu_drive.func_select == ALUFG_SEL_SUB && alu_drive.carry_in_n == ALUFG_CN_NOCARRY))
    else $error("equality test not subtract with carry pin high");
  chk_mag_select: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_MAG) |=> alu_drive.func_select == ALUFG_SEL_SUB)
    else $error("magnitude select wrong");
  chk_dbl_select: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_DBL) |=> alu_drive.func_select == ALUFG_SEL_DBL)
    else $error("double select wrong");
  chk_carry_polarity: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_ADD) |=>
    alu_drive.carry_in_n == !$past(req_carry))
    else $error("carry pin polarity wrong");
  chk_answer_timing: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid) |-> ##ALUFG_ANS_DLY ans_valid)
    else $error("answer late or early");
  chk_drive_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (!req_ready) |=> (alu_drive == $past(alu_drive) || $past(req_ready)))
    else $error("drive changed during operation");
  chk_carry_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ALUFG_WAIT && settled) |=> ans_data.carry == !$past(alu_sense.carry_out_n))
    else $error("carry capture wrong");
  chk_equal_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ALUFG_WAIT && settled) |=> ans_data.equal == $past(alu_sense.equal))
    else $error("equal capture wrong");
  chk_sub_select: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_SUB) |=>
    (alu_drive.func_select == ALUFG_SEL_SUB && alu_drive.carry_in_n == !$past(req_carry)))
    else $error("subtract not driven");
  chk_dec_no_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_DEC) |=>
    (alu_drive.func_select == ALUFG_SEL_DEC && alu_drive.carry_in_n == ALUFG_CN_NOCARRY))
    else $error("decrement not driven");
  chk_xfr_carry: assert property (@(posedge clk) disable iff (!rst_n)
    (req_ready && req_valid && req_op == ALUFG_OP_XFR) |=>
    (alu_drive.func_select == ALUFG_SEL_XFR && alu_drive.carry_in_n == ALUFG_CN_CARRY))
    else $error("transfer not driven");
  chk_result_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ALUFG_WAIT && settled) |=> ans_data.result_word == $past(alu_sense.result_word))
    else $error("result capture wrong");
  chk_lookahead_capture: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ALUFG_WAIT && settled) |=>
    (ans_data.prop_n == $past(alu_sense.prop_n) && ans_data.gen_n == $past(alu_sense.gen_n)))
    else $error("lookahead capture wrong");
  chk_ans_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ans_valid |=> !ans_valid)
    else $error("answer pulse too long");
  cov_eq: cover property (@(posedge clk) disable iff (!rst_n)
    req_ready && req_valid && req_op == ALUFG_OP_EQ);
  cov_logic: cover property (@(posedge clk) disable iff (!rst_n)
    req_ready && req_valid && req_op == ALUFG_OP_LOGIC);
  cov_b2b: cover property (@(posedge clk) disable iff (!rst_n)
    ans_valid ##1 (req_valid && req_ready));
  cov_mag: cover property (@(posedge clk) disable iff (!rst_n)
    req_ready && req_valid && req_op == ALUFG_OP_MAG);
  cov_dec: cover property (@(posedge clk) disable iff (!rst_n)
    req_ready && req_valid && req_op == ALUFG_OP_DEC);

endmodule
`default_nettype wire

// >>> verification/alufg_alu_model.sv
// behavioural model of the 4-bit ALU that the host drives
`timescale 1ns/1ps
`default_nettype none
module alufg_alu_model
  import alufg_pkg::*;
(
  input wire alufg_drive_t drv,
  output alufg_sense_t sns
);
  logic [3:0] a, b, s, t1, t2, f; // operands, select, bit terms, result
  logic [4:0] sum; // sum with carry out
  logic grp_g; // group generate
  alufg_sense_t now; // pins before settling
  // pure function of the pins, no state
  always_comb begin
    a = drv.operand_first;
    b = drv.operand_second;
    s = drv.func_select;
    t1 = a | ({4{s[0]}} & b) | ({4{s[1]}} & ~b);
    t2 = ({4{s[2]}} & a & ~b) | ({4{s[3]}} & a & b);
    sum = {1'b0, t1} + {1'b0, t2} + {4'h0, ~drv.carry_in_n};
    f = drv.mode ? ~(t1 ^ t2) : sum[3:0];
    grp_g = t2[3] | (t1[3] & t2[2]) | (&t1[3:2] & t2[1]) | (&t1[3:1] & t2[0]);
    now = '{f, ~sum[4], ~&t1, ~grp_g, &f};
  end
  // outputs settle inside the host's wait
  assign #20 sns = now;
endmodule
`default_nettype wire

// >>> verification/alufg_host_tb.sv
// self-checking bench for the ALU host controller
`timescale 1ns/1ps
`default_nettype none
module alufg_host_tb
  import alufg_pkg::*;
;
  localparam logic [63:0] LT = 64'hCEDF8A9B46570213; // logic results for a=C b=A
  logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_carry = 1'b0; // controls
  alufg_op_t req_op = ALUFG_OP_ADD; // operation
  logic [3:0] req_logic_sel = 4'h0, req_first = 4'h0, req_second = 4'h0; // fields
  logic req_ready, ans_valid; // handshake back
  alufg_drive_t alu_drive; // pins to the device
  alufg_sense_t alu_sense; // pins from the device
  alufg_answer_t ans_data; // answer
  int failures = 0, n_compared = 0, cyc = 0; // counters
  alufg_host uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_carry(req_carry), .req_logic_sel(req_logic_sel),
    .req_first(req_first), .req_second(req_second), .alu_drive(alu_drive),
    .alu_sense(alu_sense), .ans_valid(ans_valid), .ans_data(ans_data));
  alufg_alu_model alu (.drv(alu_drive), .sns(alu_sense));
  // 20 MHz clock
  always #25 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until taken, then bounded wait for the answer
  task automatic run(input alufg_op_t op, input logic c, input logic [3:0] ls, fa, fb);
    int n = 0;
    req_op = op;
    req_carry = c;
    req_logic_sel = ls;
    req_first = fa;
    req_second = fb;
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    #5 req_valid = 1'b0;
    check("ready", 8'(req_ready), 8'h00);
    while (ans_valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #5 n++;
    end
    check("answer", 8'(ans_valid), 8'h01);
  endtask
  task automatic ar(input alufg_op_t op, input logic c, input logic [3:0] fa, fb,
      input logic [4:0] e);
    run(op, c, 4'h0, fa, fb);
    check("result", 8'(ans_data.result_word), 8'(e[3:0]));
    check("carry", 8'(ans_data.carry), 8'(e[4]));
    check("mode", 8'(alu_drive.mode), 8'h00);
  endtask
  task automatic t_add();
    ar(ALUFG_OP_ADD, 1'b0, 4'h7, 4'h9, 5'h10);
    check("cn", 8'(alu_drive.carry_in_n), 8'h01);
    check("gen", 8'(ans_data.gen_n), 8'h00);
    ar(ALUFG_OP_ADD, 1'b1, 4'h5, 4'hA, 5'h10);
    check("cn", 8'(alu_drive.carry_in_n), 8'h00);
    check("prop", 8'(ans_data.prop_n), 8'h00);
    check("gen", 8'(ans_data.gen_n), 8'h01);
    $display("add test done");
  endtask
  task automatic t_sub();
    ar(ALUFG_OP_SUB, 1'b0, 4'h5, 4'h3, 5'h11);
    ar(ALUFG_OP_SUB, 1'b1, 4'h5, 4'h3, 5'h12);
    ar(ALUFG_OP_SUB, 1'b1, 4'h3, 4'h5, 5'h0E);
    check("sel", 8'(alu_drive.func_select), 8'h06);
    $display("sub test done");
  endtask
  task automatic t_cmp();
    ar(ALUFG_OP_EQ, 1'b0, 4'h9, 4'h9, 5'h0F);
    check("eq", 8'(ans_data.equal), 8'h01);
    check("cn", 8'(alu_drive.carry_in_n), 8'h01);
    ar(ALUFG_OP_EQ, 1'b1, 4'h9, 4'h8, 5'h10);
    check("eq", 8'(ans_data.equal), 8'h00);
    ar(ALUFG_OP_MAG, 1'b0, 4'h2, 4'h7, 5'h0B);
    ar(ALUFG_OP_MAG, 1'b0, 4'h7, 4'h2, 5'h15);
    check("sel", 8'(alu_drive.func_select), 8'h06);
    $display("compare test done");
  endtask
  task automatic t_misc();
    ar(ALUFG_OP_DEC, 1'b1, 4'h0, 4'h0, 5'h0F);
    ar(ALUFG_OP_DEC, 1'b0, 4'h6, 4'h0, 5'h15);
    ar(ALUFG_OP_XFR, 1'b0, 4'hB, 4'h2, 5'h1B);
    ar(ALUFG_OP_DBL, 1'b1, 4'h9, 4'h0, 5'h13);
    check("sel", 8'(alu_drive.func_select), 8'h0C);
    $display("misc test done");
  endtask
  task automatic t_logic();
    for (int s = 0; s < 16; s++) begin
      run(ALUFG_OP_LOGIC, 1'b0, 4'(s), 4'hC, 4'hA);
      check("logic", 8'(ans_data.result_word), 8'(LT[4*s+:4]));
      check("mode", 8'(alu_drive.mode), 8'h01);
      check("eq", 8'(ans_data.equal), 8'(s == 12));
    end
    $display("logic test done");
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(posedge clk);
    #5 rst_n = 1'b1;
    t_add();
    t_sub();
    t_cmp();
    t_misc();
    t_logic();
    end_sim();
  end
endmodule
`default_nettype wire
